//--- common/lbic_regs.vh
`ifndef LBIC_REGS_VH
`define LBIC_REGS_VH

// Target address and byte shape
`define LBIC_DEV_ADDR 7'h36
`define LBIC_BYTE_BITS 4'h8

// Register addresses
`define LBIC_OFS_GP 8'h10
`define LBIC_OFS_MAIN 8'hA0
`define LBIC_OFS_AUX 8'hB0
`define LBIC_OFS_IND 8'hC0

// Power-on values
`define LBIC_RST_GP 8'h20
`define LBIC_RST_MAIN 8'hE0
`define LBIC_RST_AUX 8'hE0
`define LBIC_RST_IND 8'hFC

// General purpose field positions
`define LBIC_GP_MAIN_EN 0
`define LBIC_GP_AUX_EN 1
`define LBIC_GP_IND_EN 2
`define LBIC_GP_SENSE5 3
`define LBIC_GP_THIRD_AUX 4
`define LBIC_GP_WMASK 8'h1F

// Fixed upper bits of the brightness registers
`define LBIC_MAIN_FIXED 8'hE0
`define LBIC_AUX_FIXED 8'hE0
`define LBIC_IND_FIXED 8'hFC

// Timing
`define LBIC_CLK_HZ 20000000
`define LBIC_PWM_HZ 20000
`define LBIC_PWM_PERIOD_CYC (`LBIC_CLK_HZ / `LBIC_PWM_HZ)

`endif

//--- hw/lbic_pwm.v
// Brightness code decoder and duty generator for one dimmed group
module lbic_pwm #(
  parameter PERIOD = 1000
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [9:0] phase_in,
  input wire [4:0] code_in,
  output reg [1:0] level_out,
  output reg on_out
);
  localparam [10:0] PER = PERIOD[10:0];

  // Code to {analog level, duty in sixteenths}
  function [6:0] lbic_decode;
    input [4:0] code;
    begin
      if (code < 5'h10) begin
        lbic_decode = {2'h0, code + 5'h01};
      end else if (code < 5'h17) begin
        lbic_decode = {2'h1, code - 5'h06};
      end else if (code < 5'h1D) begin
        lbic_decode = {2'h2, code - 5'h0C};
      end else if (code == 5'h1D) begin
        lbic_decode = {2'h3, 5'h0D};
      end else if (code == 5'h1E) begin
        lbic_decode = {2'h3, 5'h0F};
      end else begin
        lbic_decode = {2'h3, 5'h10};
      end
    end
  endfunction

  wire [6:0] dec = lbic_decode(code_in);
  wire [15:0] prod = {11'h000, dec[4:0]} * {5'h00, PER};
  wire [11:0] thr = prod[15:4];

  // Sink on for duty sixteenths of each period
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      level_out <= 2'h0;
      on_out <= 1'b0;
    end else begin
      level_out <= dec[6:5];
      on_out <= ({2'h0, phase_in} < thr);
    end
  end
endmodule // lbic_pwm

//--- hw/lbic_gain.v
// Charge pump gain selection from headroom of active sinks
module lbic_gain (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire [4:0] main_low_in,
  input wire [2:0] aux_low_in,
  input wire main_en_in,
  input wire aux_en_in,
  input wire sense5_in,
  input wire third_aux_in,
  output reg gain_high_out
);
  // Only enabled, sensed sinks count; indicator has no input here
  wire [4:0] main_mask = {sense5_in, 4'hF} & {5{main_en_in}};
  wire [2:0] aux_mask = {third_aux_in, 2'h3} & {3{aux_en_in}};
  wire any_low = |(main_low_in & main_mask) | |(aux_low_in & aux_mask);
  wire any_mon = |main_mask | |aux_mask;

  // Unity by default, 3/2 once headroom drops, unity when nothing monitored
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gain_high_out <= 1'b0;
    end else if (!any_mon) begin
      gain_high_out <= 1'b0;
    end else if (any_low) begin
      gain_high_out <= 1'b1;
    end
  end
endmodule // lbic_gain

//--- hw/lbic_top.v
`include "lbic_regs.vh"

// Write-only serial target, register bank, dimming and gain control
module lbic_top #(
  parameter PWM_PERIOD = `LBIC_PWM_PERIOD_CYC
) (
  input wire core_clk_in,
  input wire reset_n_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_out,
  input wire [4:0] main_headroom_low_in,
  input wire [2:0] aux_headroom_low_in,
  output reg [4:0] main_sink_on_out,
  output reg [2:0] aux_sink_on_out,
  output reg indicator_sink_on_out,
  output reg [1:0] main_level_out,
  output reg [1:0] aux_level_out,
  output reg [1:0] indicator_level_out,
  output reg pump_gain_high_out,
  output reg bus_busy_out
);
  // Transfer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_REG = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;
  localparam [9:0] PHASE_LAST = PWM_PERIOD[9:0] - 10'h001;

  // Line synchronisers; stage 1 feeds stage 2 only
  reg scl_s1;
  reg scl_s2;
  reg scl_s3;
  reg sda_s1;
  reg sda_s2;
  reg sda_s3;
  reg [4:0] main_hr_s1;
  reg [4:0] main_hr_s2;
  reg [2:0] aux_hr_s1;
  reg [2:0] aux_hr_s2;

  // Target state
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [7:0] reg_addr;
  reg in_ack;

  // Register bank
  reg [7:0] gp_enables;
  reg [7:0] main_bank_brightness;
  reg [7:0] aux_bank_brightness;
  reg [7:0] indicator_brightness;

  // Dimming phase
  reg [9:0] pwm_phase;

  wire main_pwm_on;
  wire aux_pwm_on;
  wire [1:0] main_lvl;
  wire [1:0] aux_lvl;
  wire gain_high;

  // Edges and bus conditions, seen on the synchronised lines
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  wire [7:0] byte_now = shift;

  wire main_group_enable = gp_enables[`LBIC_GP_MAIN_EN];
  wire aux_group_enable = gp_enables[`LBIC_GP_AUX_EN];
  wire indicator_enable = gp_enables[`LBIC_GP_IND_EN];
  wire fifth_main_sense_enable = gp_enables[`LBIC_GP_SENSE5];
  wire third_aux_sink_enable = gp_enables[`LBIC_GP_THIRD_AUX];

  // Three-stage capture of the bus lines, two-stage capture of the headroom flags
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      main_hr_s1 <= 5'h00;
      main_hr_s2 <= 5'h00;
      aux_hr_s1 <= 3'h0;
      aux_hr_s2 <= 3'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      main_hr_s1 <= main_headroom_low_in;
      main_hr_s2 <= main_hr_s1;
      aux_hr_s1 <= aux_headroom_low_in;
      aux_hr_s2 <= aux_hr_s1;
    end
  end

  // Bus occupancy between start and stop
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bus_busy_out <= 1'b0;
    end else if (start_det) begin
      bus_busy_out <= 1'b1;
    end else if (stop_det) begin
      bus_busy_out <= 1'b0;
    end
  end

  // Receive state machine: bits taken on clock rise, ack on clock low
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      reg_addr <= 8'h00;
      in_ack <= 1'b0;
      sda_oe_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE;
        bit_cnt <= 4'h0;
        in_ack <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (state != ST_IDLE) begin
        if (scl_rise && !in_ack && bit_cnt < `LBIC_BYTE_BITS) begin
          shift <= {shift[6:0], sda_s2};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (scl_fall && in_ack) begin
          // End of the ninth pulse: release the line
          in_ack <= 1'b0;
          sda_oe_out <= 1'b0;
          bit_cnt <= 4'h0;
        end else if (scl_fall && bit_cnt == `LBIC_BYTE_BITS) begin
          in_ack <= 1'b1;
          case (state)
            ST_ADDR: begin
              if (byte_now[7:1] == `LBIC_DEV_ADDR && !byte_now[0]) begin
                sda_oe_out <= 1'b1;
                state <= ST_REG;
              end else begin
                sda_oe_out <= 1'b0;
                state <= ST_IGNORE;
              end
            end
            ST_REG: begin
              reg_addr <= byte_now;
              sda_oe_out <= 1'b1;
              state <= ST_DATA;
            end
            ST_DATA: begin
              sda_oe_out <= 1'b1;
            end
            default: begin
              sda_oe_out <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Data byte completes on the falling edge that opens the ack slot
  wire wr_strobe = !start_det && !stop_det && state == ST_DATA && !in_ack &&
    scl_fall && bit_cnt == `LBIC_BYTE_BITS;

  // Register bank writes; upper fixed bits always hold their power-on values
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gp_enables <= `LBIC_RST_GP;
      main_bank_brightness <= `LBIC_RST_MAIN;
      aux_bank_brightness <= `LBIC_RST_AUX;
      indicator_brightness <= `LBIC_RST_IND;
    end else if (wr_strobe) begin
      if (reg_addr == `LBIC_OFS_GP) begin
        gp_enables <= (byte_now & `LBIC_GP_WMASK) | `LBIC_RST_GP;
      end else if (reg_addr == `LBIC_OFS_MAIN) begin
        main_bank_brightness <= byte_now | `LBIC_MAIN_FIXED;
      end else if (reg_addr == `LBIC_OFS_AUX) begin
        aux_bank_brightness <= byte_now | `LBIC_AUX_FIXED;
      end else if (reg_addr == `LBIC_OFS_IND) begin
        indicator_brightness <= byte_now | `LBIC_IND_FIXED;
      end
      // Any other address leaves the bank untouched
    end
  end

  // Free-running dimming phase, one period per 20 kHz cycle
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_phase <= 10'h000;
    end else if (pwm_phase == PHASE_LAST) begin
      pwm_phase <= 10'h000;
    end else begin
      pwm_phase <= pwm_phase + 10'h001;
    end
  end

  // Main group dimming
  lbic_pwm #(
    .PERIOD(PWM_PERIOD)
  ) u_main_pwm (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .phase_in(pwm_phase),
    .code_in(main_bank_brightness[4:0]),
    .level_out(main_lvl),
    .on_out(main_pwm_on)
  );

  // Aux group dimming
  lbic_pwm #(
    .PERIOD(PWM_PERIOD)
  ) u_aux_pwm (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .phase_in(pwm_phase),
    .code_in(aux_bank_brightness[4:0]),
    .level_out(aux_lvl),
    .on_out(aux_pwm_on)
  );

  // Pump gain from monitored headroom
  lbic_gain u_gain (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .main_low_in(main_hr_s2),
    .aux_low_in(aux_hr_s2),
    .main_en_in(main_group_enable),
    .aux_en_in(aux_group_enable),
    .sense5_in(fifth_main_sense_enable),
    .third_aux_in(third_aux_sink_enable),
    .gain_high_out(gain_high)
  );

  // Registered sink drives and levels
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      main_sink_on_out <= 5'h00;
      aux_sink_on_out <= 3'h0;
      indicator_sink_on_out <= 1'b0;
      main_level_out <= 2'h0;
      aux_level_out <= 2'h0;
      indicator_level_out <= 2'h0;
      pump_gain_high_out <= 1'b0;
    end else begin
      main_sink_on_out <= {5{main_group_enable & main_pwm_on}};
      aux_sink_on_out <= {third_aux_sink_enable, 2'h3} & {3{aux_group_enable & aux_pwm_on}};
      indicator_sink_on_out <= indicator_enable;
      main_level_out <= main_lvl;
      aux_level_out <= aux_lvl;
      indicator_level_out <= indicator_brightness[1:0];
      pump_gain_high_out <= gain_high;
    end
  end
endmodule // lbic_top

//--- test/lbic_checker.sv
module lbic_checker (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic [4:0] main_headroom_low_in,
  input wire logic [2:0] aux_headroom_low_in,
  input wire logic [4:0] main_sink_on_out,
  input wire logic [2:0] aux_sink_on_out,
  input wire logic indicator_sink_on_out,
  input wire logic pump_gain_high_out,
  input wire logic bus_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  int since_low;
  // Cycles since any headroom comparator last reported low
  always_ff @(posedge core_clk_in or negedge reset_n_in)
    if (!reset_n_in) since_low <= 99;
    else if (|main_headroom_low_in || |aux_headroom_low_in) since_low <= 0;
    else if (since_low < 99) since_low <= since_low + 1;
  sequence s_start; scl_in && $fell(sda_in); endsequence
  sequence s_stop; scl_in && $rose(sda_in); endsequence
  sequence s_ack_hold; sda_oe_out [*6] ##[1:8] !sda_oe_out; endsequence
  property p_busy_set; s_start |-> ##[1:6] bus_busy_out; endproperty
  property p_busy_clr; s_stop |-> ##[1:6] !bus_busy_out; endproperty
  property p_ack_hold; $rose(sda_oe_out) |-> s_ack_hold; endproperty
  property p_ack_scl_low; $changed(sda_oe_out) |-> !scl_in; endproperty
  property p_drive_low; sda_oe_out |-> !sda_out && bus_busy_out; endproperty
  property p_reset_clear; $rose(reset_n_in) |-> {main_sink_on_out, aux_sink_on_out, indicator_sink_on_out,
    pump_gain_high_out, bus_busy_out, sda_oe_out} == 12'h000; endproperty
  property p_main_together; main_sink_on_out == 5'h00 || main_sink_on_out == 5'h1F; endproperty
  property p_third_aux; aux_sink_on_out[2] |-> aux_sink_on_out[1]; endproperty
  property p_gain_cause; $rose(pump_gain_high_out) |-> since_low < 8; endproperty
  a_busy_set: assert property (p_busy_set) else $error("no busy after start");
  a_busy_clr: assert property (p_busy_clr) else $error("busy after stop");
  a_ack_hold: assert property (p_ack_hold) else $error("ack width wrong");
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("data moved with clock high");
  a_drive_low: assert property (p_drive_low) else $error("bad data drive");
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
  a_main_together: assert property (p_main_together) else $error("main sinks split");
  a_third_aux: assert property (p_third_aux) else $error("third aux sink alone");
  a_gain_cause: assert property (p_gain_cause) else $error("gain rose without cause");
endmodule // lbic_checker

bind lbic_top lbic_checker u_lbic_checker (.core_clk_in, .reset_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
  .main_headroom_low_in, .aux_headroom_low_in, .main_sink_on_out, .aux_sink_on_out, .indicator_sink_on_out,
  .pump_gain_high_out, .bus_busy_out);

//--- test/lbic_master.sv
module lbic_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // One clock pulse: data set while low, sampled in the high phase
  task automatic pulse(input logic d, output logic s);
    scl_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    sda_low_out <= ~d;
    repeat (2) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (2) @(posedge clk_in);
    s = sda_in;
    @(posedge clk_in);
  endtask
  // Start when hi_first is set, stop otherwise
  task automatic cond(input logic hi_first);
    scl_out <= 1'b0;
    repeat (3) @(posedge clk_in);
    sda_low_out <= ~hi_first;
    repeat (3) @(posedge clk_in);
    scl_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    sda_low_out <= hi_first;
    repeat (3) @(posedge clk_in);
  endtask
  // Eight bits then the acknowledge pulse with data released
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i], s);
    pulse(1'b1, ack);
  endtask
endmodule // lbic_master

//--- test/tb_led_bank_i2c_control.sv
module tb_led_bank_i2c_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, sda_w, scl, m_low, sda_o, sda_oe, ind_on, gain, busy, k;
  logic [4:0] mh = 5'h00, m_on;
  logic [2:0] ah = 3'h0, a_on;
  logic [1:0] m_lv, a_lv, i_lv;
  logic [7:0] tbl [5] = '{8'h10, 8'hA0, 8'hB0, 8'hC0, 8'h5A};
  int bad_count = 0, n_checks = 0, gp, ra, rb, rc, g;
  always #25 clk = ~clk;
  // Open-drain data wire with pull-up
  assign sda_w = !(m_low || (sda_oe && !sda_o));
  lbic_master u_lbic_master (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_low_out(m_low));
  lbic_top #(.PWM_PERIOD(16)) u_lbic_top (.core_clk_in(clk), .reset_n_in(rst_n), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .main_headroom_low_in(mh), .aux_headroom_low_in(ah),
    .main_sink_on_out(m_on), .aux_sink_on_out(a_on), .indicator_sink_on_out(ind_on), .main_level_out(m_lv),
    .aux_level_out(a_lv), .indicator_level_out(i_lv), .pump_gain_high_out(gain), .bus_busy_out(busy));
  function automatic int duty(int c);
    return c < 16 ? c + 1 : c < 23 ? c - 6 : c < 29 ? c - 12 : c == 29 ? 13 : c == 30 ? 15 : 16;
  endfunction
  function automatic int lvl(int c);
    return c < 16 ? 0 : c < 23 ? 1 : c < 29 ? 2 : 3;
  endfunction
  task automatic chk(input logic [7:0] seen, input int exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic defaults();
    gp = 32;
    ra = 0;
    rb = 0;
    rc = 0;
    g = 0;
  endtask
  // Full write transfer; acks and model update
  task automatic wr(input logic [7:0] a, input logic [7:0] r, input logic [7:0] d);
    logic ok;
    ok = (a == 8'h6C);
    u_lbic_master.cond(1'b1);
    u_lbic_master.send(a, k);
    chk(k, !ok);
    u_lbic_master.send(r, k);
    chk(k, !ok);
    u_lbic_master.send(d, k);
    chk(k, !ok);
    u_lbic_master.cond(1'b0);
    if (ok && r == 8'h10) gp = d;
    if (ok && r == 8'hA0) ra = d[4:0];
    if (ok && r == 8'hB0) rb = d[4:0];
    if (ok && r == 8'hC0) rc = d[1:0];
    if (gp[1:0] == 0) g = 0;
  endtask
  // Sink duty over one dimming period, then steady outputs
  task automatic check_all();
    int cm, ca, c3;
    cm = 0;
    ca = 0;
    c3 = 0;
    repeat (16) begin
      @(negedge clk);
      cm += m_on[0];
      ca += a_on[0];
      c3 += a_on[2];
    end
    chk(8'(cm), gp[0] ? duty(ra) : 0);
    chk(8'(ca), gp[1] ? duty(rb) : 0);
    chk(8'(c3), gp[1] && gp[4] ? duty(rb) : 0);
    chk(ind_on, gp[2]);
    if (gp[0]) chk(m_lv, lvl(ra));
    if (gp[1]) chk(a_lv, lvl(rb));
    if (gp[2]) chk(i_lv, rc);
    chk(gain, g);
    // Hand back on a rising edge so the next bus task drives off it
    @(posedge clk);
  endtask
  // Random headroom flags, gain compared with the model
  task automatic head();
    @(posedge clk);
    mh <= 5'($urandom);
    ah <= 3'($urandom);
    repeat (8) @(posedge clk);
    if (gp[1:0] != 0 && |((gp[0] ? {gp[3], 4'hF} : 5'h00) & mh | (gp[1] ? {gp[4], 2'h3} : 3'h0) & ah)) g = 1;
    chk(gain, g);
    mh <= 5'h00;
    ah <= 3'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    k = $urandom(27487);
    defaults();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check_all();
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      wr(8'h6C, tbl[i % 5], (i % 5 == 0) ? 8'($urandom) | 8'h03 : 8'($urandom));
      check_all();
      head();
      $display("test %0d done", i);
    end
    wr(8'h6E, 8'hA0, 8'h00);
    wr(8'h6D, 8'hB0, 8'h00);
    check_all();
    u_lbic_master.cond(1'b1);
    u_lbic_master.send(8'h6C, k);
    u_lbic_master.send(8'hA0, k);
    wr(8'h6C, 8'hB0, 8'h1D);
    check_all();
    wr(8'h6C, 8'h10, 8'h00);
    check_all();
    wr(8'h6C, 8'h10, 8'h1F);
    head();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    defaults();
    repeat (4) @(posedge clk);
    check_all();
    $display("test final done");
    stop_test();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    bad_count++;
    stop_test();
  end
endmodule // tb_led_bank_i2c_control
